// File: dv/aos_dac_model.sv
// Converter model that takes all four channel codes at its own update rate.
`timescale 1ns/10ps
`default_nettype none

module aos_dac_model #(
  parameter int PERIOD = 4
) (
  input wire logic clk_sys,
  input wire logic signed [15:0] code0,
  input wire logic signed [15:0] code1,
  input wire logic signed [15:0] code2,
  input wire logic signed [15:0] code3,
  output logic [3:0][15:0] held,
  output logic convDone
);
  // Free-running divider that paces the conversions.
  logic [7:0] cnt = 8'h00;

  // All channels are latched together, as one update strobe would do.
  always_ff @(posedge clk_sys) begin
    cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
    convDone <= (cnt == 8'h00);
    if (cnt == 8'h00) begin
      held <= {code3, code2, code1, code0};
    end
  end
endmodule
`default_nettype wire

// File: dv/aos_properties.sv
// Concurrent checks on the output source selector's ports.
`timescale 1ns/10ps
`default_nettype none

module aos_properties (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic signed [15:0] xPct,
  input wire logic signed [15:0] yPct,
  input wire logic signed [15:0] magPct,
  input wire logic signed [15:0] phaseCdeg,
  input wire logic signed [15:0] eq1,
  input wire logic signed [15:0] dacCode0,
  input wire logic noiseWarning
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Shadow of the channel 0 source and of noise mode, rebuilt from writes.
  logic [3:0] sel0;
  logic [3:0] next_sel0;
  logic noiseOn;
  logic next_noiseOn;

  // Saturating clamp used by the scaling checks.
  function automatic int sat(input int v, input int lo, input int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Next shadow state from a write in its access cycle.
  always_comb begin
    next_sel0 = sel0;
    next_noiseOn = noiseOn;
    if (psel && penable && pwrite) begin
      if (paddr == 8'h00) begin
        next_noiseOn = pwdata[0];
      end else if (paddr == 8'h04 && pwdata[3:0] <= 4'hd) begin
        next_sel0 = pwdata[3:0];
      end else if (paddr == 8'h18) begin
        next_noiseOn = noiseOn | pwdata[8];
        if (pwdata[9] && !noiseOn && sel0 == 4'h4) begin
          next_sel0 = 4'h9;
        end
      end
    end
  end

  // Shadow registers start from the documented reset values.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sel0 <= 4'h9;
      noiseOn <= 1'b0;
    end else begin
      sel0 <= next_sel0;
      noiseOn <= next_noiseOn;
    end
  end

  sequence picked_s(logic [3:0] code);
    sel0 == code;
  endsequence
  sequence noise_off_s;
    picked_s(4'h4) ##0 !noiseOn;
  endsequence

  chk_x_scale: assert property (picked_s(4'h0) |=>
    int'(dacCode0) == sat(int'($past(xPct)) >>> 2, -7500, 7500))
    else $error("channel 0 X scaling wrong");
  chk_y_scale: assert property (picked_s(4'h1) |=>
    int'(dacCode0) == sat(int'($past(yPct)) >>> 2, -7500, 7500))
    else $error("channel 0 Y scaling wrong");
  chk_mag_scale: assert property (picked_s(4'h2) |=>
    int'(dacCode0) == sat(int'($past(magPct)) >>> 2, 0, 7500))
    else $error("channel 0 magnitude scaling wrong");
  chk_phase_scale: assert property (picked_s(4'h3) |=>
    int'(dacCode0) == sat(int'($past(phaseCdeg)) >>> 1, -10000, 10000))
    else $error("channel 0 phase scaling wrong");
  chk_eq_scale: assert property (picked_s(4'h7) |=>
    int'(dacCode0) == sat(int'($past(eq1)), -10000, 10000))
    else $error("channel 0 equation scaling wrong");
  chk_code_range: assert property (dacCode0 >= -16'sd10000 && dacCode0 <= 16'sd10000)
    else $error("channel 0 code outside converter range");
  chk_warn_set: assert property (noise_off_s |-> noiseWarning)
    else $error("noise warning missing");
  chk_warn_clear: assert property (noiseOn |-> !noiseWarning)
    else $error("noise warning with noise mode on");
endmodule

bind aos_top aos_properties aos_properties_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .xPct(xPct), .yPct(yPct),
  .magPct(magPct), .phaseCdeg(phaseCdeg), .eq1(eq1), .dacCode0(dacCode0),
  .noiseWarning(noiseWarning));
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the output source selector with a converter model.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic noiseWarning, convDone;
  logic errSeen, ok;
  // Inputs: X, Y, MAG, NOISE, PHASE, EQ1, EQ2, ADC, DEMOD2, AUX1, SYNC.
  logic signed [15:0] inp [11] = '{default: 16'h0};
  logic signed [15:0] dac [4];
  logic [3:0][15:0] held;
  logic [17:0] notes [$];
  logic [31:0] rd;
  logic [3:0] srcs [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
  logic [15:0] rx [4] = '{16'h07d0, 16'hfe0c, 16'h0bb8, 16'h7530};
  logic [15:0] ra [4] = '{16'h03e8, 16'h03e8, 16'h0000, 16'h0002};
  logic [15:0] rr [4] = '{16'h07d0, 16'hfe0c, 16'h2710, 16'h2710};
  int rlo [4] = '{281, -3000, 2000, 2000};
  int rhi [4] = '{321, -3000, 2000, 2000};
  int lvl;
  int n_mismatch = 0;
  int cmp_count = 0;

  // Free-running 200 MHz clock.
  always #2.5 clk_sys = ~clk_sys;

  aos_top aos_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xPct(inp[0]), .yPct(inp[1]), .magPct(inp[2]), .noisePct(inp[3]),
    .phaseCdeg(inp[4]), .eq1(inp[5]), .eq2(inp[6]), .adcMon(inp[7]), .demod2Mon(inp[8]),
    .aux1Mv(inp[9]), .syncSine(inp[10]), .dacCode0(dac[0]), .dacCode1(dac[1]),
    .dacCode2(dac[2]), .dacCode3(dac[3]), .noiseWarning(noiseWarning));
  aos_dac_model #(.PERIOD(4)) aos_dac_model_i (.clk_sys(clk_sys), .code0(dac[0]),
    .code1(dac[1]), .code2(dac[2]), .code3(dac[3]), .held(held), .convDone(convDone));

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; entered just after a rising edge, ends one idle edge later.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_mismatch++;
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Notes an expected code once the path has settled, then waits for its comparison.
  task automatic exp_dac(input logic [1:0] ch, input logic [15:0] v);
    int k;
    repeat (3) @(posedge clk_sys);
    notes.push_back({ch, v});
    for (k = 0; k < 40 && notes.size() > 0; k++) @(posedge clk_sys);
  endtask

  // Applies full-scale, negative full-scale or random input values.
  task automatic drive_in(input int r);
    for (int i = 0; i < 11; i++) begin
      if (r > 1) begin
        inp[i] <= (i == 4) ? 16'($urandom_range(36000) - 18000) : 16'($urandom());
      end else begin
        inp[i] <= (i == 4) ? ((r == 0) ? 16'h4650 : 16'hb9b0) : ((r == 0) ? 16'h7fff : 16'h8000);
      end
    end
  endtask

  function automatic int sat(input int v, input int lo, input int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Expected converter code of channel 0 for a source.
  function automatic logic [15:0] model_out(input logic [3:0] s);
    int v;
    case (s)
      4'h0: v = sat(inp[0] >>> 2, -7500, 7500);
      4'h1: v = sat(inp[1] >>> 2, -7500, 7500);
      4'h2: v = sat(inp[2] >>> 2, 0, 7500);
      4'h4: v = sat(inp[3] >>> 2, 0, 7500);
      4'h3: v = inp[4] >>> 1;
      4'h7: v = sat(inp[5], -10000, 10000);
      4'h8: v = sat(inp[6], -10000, 10000);
      4'h9: v = sat(lvl, -10000, 10000);
      4'ha: v = (int'(inp[7]) * 10000) >>> 15;
      4'hb: v = (int'(inp[8]) * 10000) >>> 15;
      4'hc: v = sat(inp[9], -10000, 10000);
      default: v = (int'(inp[10]) * 10000) >>> 15;
    endcase
    return v[15:0];
  endfunction

  // Compares the oldest note with the converter's latest sample.
  always @(posedge clk_sys) begin
    if (convDone === 1'b1 && notes.size() > 0) begin
      check(held[notes[0][17:16]], notes[0][15:0]);
      void'(notes.pop_front());
    end
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end

  task automatic summarize();
    if (notes.size() > 0) n_mismatch++;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    void'($urandom(32'he19f));
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[15:0], 16'h9999);
    apb(1'b1, 8'h40, 32'hffff_ffff);
    check(errSeen, 1'b1);
    for (int c = 1; c < 4; c++) begin
      apb(1'b1, 8'(8 + 4 * c), 32'(-1000 * c));
      exp_dac(2'(c), 16'(-1000 * c));
    end
    $display("test defaults done");
    for (int r = 0; r < 4; r++) begin
      lvl = (r == 0) ? 12000 : $urandom_range(24000) - 12000;
      apb(1'b1, 8'h08, 32'(lvl));
      for (int i = 0; i < 12; i++) begin
        drive_in(r);
        apb(1'b1, 8'h04, {16'h0, 12'h999, srcs[i]});
        exp_dac(2'd0, model_out(srcs[i]));
      end
    end
    $display("test sources done");
    apb(1'b1, 8'h04, 32'h0000_9994);
    check(noiseWarning, 1'b1);
    apb(1'b1, 8'h18, 32'h0000_0100);
    apb(1'b0, 8'h00, 32'h0);
    check({rd[0], noiseWarning}, 2'b10);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h18, 32'h0000_0200);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[15:0], 16'h9999);
    apb(1'b1, 8'h04, 32'h0000_9a99);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[15:0], 16'h9999);
    apb(1'b0, 8'h18, 32'h0);
    check(rd[7:4], 4'h4);
    $display("test noise and refusal done");
    apb(1'b1, 8'h04, 32'h0000_9965);
    for (int i = 0; i < 4; i++) begin
      inp[0] <= rx[i];
      inp[9] <= ra[i];
      repeat (60) @(posedge clk_sys);
      apb(1'b0, 8'h1c, 32'h0);
      check(rd[15:0], rr[i]);
      ok = $signed(rd[31:16]) >= rlo[i] && $signed(rd[31:16]) <= rhi[i];
      check(ok, 1'b1);
      exp_dac(2'd0, rr[i]);
      if (rlo[i] == rhi[i]) exp_dac(2'd1, 16'(rlo[i]));
    end
    $display("test ratio done");
    summarize();
  end
endmodule
`default_nettype wire

// File: hdl/aos_pkg.sv
// Types and shared arithmetic of the output source selector.
package aos_pkg;

  // Sources that a channel selector may pick.
  typedef enum logic [3:0] {
    AOS_SRC_X = 4'h0,
    AOS_SRC_Y = 4'h1,
    AOS_SRC_MAG = 4'h2,
    AOS_SRC_PHASE = 4'h3,
    AOS_SRC_NOISE = 4'h4,
    AOS_SRC_RATIO = 4'h5,
    AOS_SRC_LOGRATIO = 4'h6,
    AOS_SRC_EQ1 = 4'h7,
    AOS_SRC_EQ2 = 4'h8,
    AOS_SRC_LEVEL = 4'h9,
    AOS_SRC_ADCMON = 4'ha,
    AOS_SRC_DEMOD2MON = 4'hb,
    AOS_SRC_AUX1MON = 4'hc,
    AOS_SRC_SYNC = 4'hd
  } aos_src_e;

  // Converter code, signed millivolts.
  typedef logic signed [15:0] aos_mv_t;

  // Ratio divider states, Gray coded from IDLE through RUN to DONE; the return to IDLE flips both bits.
  typedef enum logic [1:0] {
    AOS_DIV_IDLE = 2'b00,
    AOS_DIV_RUN = 2'b01,
    AOS_DIV_DONE = 2'b11
  } aos_div_e;

  // Saturates a wide value into a window instead of letting it wrap.
  function automatic aos_mv_t aos_sat(input logic signed [31:0] v,
                                      input logic signed [31:0] lo,
                                      input logic signed [31:0] hi);
    logic signed [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r[15:0];
  endfunction

endpackage

// File: hdl/aos_ratio.sv
// Ratio of X against auxiliary input 1 and its base-10 logarithm.
`timescale 1ns/10ps
`default_nettype none
`include "aos_regs.svh"

module aos_ratio import aos_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstSync_n,
  input wire logic signed [15:0] xPct,
  input wire logic signed [15:0] aux1Mv,
  output logic signed [15:0] ratioMv,
  output logic signed [15:0] logMv
);

  // Rounded 16 * log2(1 + i/16) for the four mantissa bits.
  function automatic logic [4:0] mantLog(input logic [3:0] f);
    logic [4:0] t;
    case (f)
      4'h0: t = 5'd0;
      4'h1: t = 5'd1;
      4'h2: t = 5'd3;
      4'h3: t = 5'd4;
      4'h4: t = 5'd5;
      4'h5: t = 5'd6;
      4'h6: t = 5'd7;
      4'h7: t = 5'd8;
      4'h8: t = 5'd9;
      4'h9: t = 5'd10;
      4'ha: t = 5'd11;
      4'hb: t = 5'd12;
      4'hc: t = 5'd13;
      4'hd: t = 5'd14;
      default: t = 5'd15;
    endcase
    return t;
  endfunction

  // Thousandths of log10 of a positive ratio held in thousandths, clamped.
  function automatic aos_mv_t logMilli(input logic [25:0] q);
    int e;
    logic [25:0] n;
    logic signed [31:0] l16;
    e = 0;
    for (int i = 0; i < 26; i++) begin
      if (q[i]) begin
        e = i;
      end
    end
    n = (e >= 4) ? (q >> (e - 4)) : (q << (4 - e));
    l16 = e * 16 + 32'(mantLog(n[3:0]));
    return aos_sat(((l16 * `AOS_LOG10_2_MILLI) >>> 4) + `AOS_LOG_MIN, `AOS_LOG_MIN, `AOS_LOG_MAX);
  endfunction

  aos_div_e state, next_state; // Divider sequence.
  logic [25:0] quo, next_quo; // Dividend shifting out, quotient shifting in.
  logic [16:0] rem, next_rem; // Partial remainder.
  logic [15:0] dvs, next_dvs; // Divisor magnitude.
  logic neg, next_neg; // Sign of the result.
  logic [4:0] cnt, next_cnt; // Steps left.
  logic signed [15:0] next_ratioMv, next_logMv;
  logic [16:0] remShift; // Remainder after taking the next dividend bit.
  logic [31:0] absX; // Magnitude of X.
  logic [15:0] absA; // Magnitude of the auxiliary voltage.

  // Computes the next divider step and the results at its end.
  always_comb begin
    absX = xPct[15] ? 32'(-32'(xPct)) : 32'(xPct);
    absA = aux1Mv[15] ? 16'(-aux1Mv) : 16'(aux1Mv);
    remShift = {rem[15:0], quo[25]};
    next_state = state;
    next_quo = quo;
    next_rem = rem;
    next_dvs = dvs;
    next_neg = neg;
    next_cnt = cnt;
    next_ratioMv = ratioMv;
    next_logMv = logMv;
    case (state)
      AOS_DIV_IDLE: begin
        // Start ten X over auxiliary volts.
        next_quo = 26'(absX * 32'(`AOS_MV_PER_RATIO));
        next_rem = 17'h00000;
        next_dvs = absA;
        next_neg = xPct[15] ^ aux1Mv[15];
        next_cnt = `AOS_DIV_STEPS;
        if (absA < `AOS_AUX_MIN_MV) begin
          next_ratioMv = (xPct == 16'sh0000) ? 16'sh0000 :
                         (xPct[15] ? aos_sat(`AOS_MV_MIN, `AOS_MV_MIN, `AOS_MV_MAX) :
                          aos_sat(`AOS_MV_MAX, `AOS_MV_MIN, `AOS_MV_MAX));
          next_logMv = xPct[15] ? aos_sat(`AOS_LOG_MIN, `AOS_LOG_MIN, `AOS_LOG_MAX) :
                       aos_sat(`AOS_LOG_MAX, `AOS_LOG_MIN, `AOS_LOG_MAX);
        end else begin
          next_state = AOS_DIV_RUN;
        end
      end
      AOS_DIV_RUN: begin
        // Restoring division, one quotient bit per clock.
        if (remShift >= {1'b0, dvs}) begin
          next_rem = remShift - {1'b0, dvs};
          next_quo = {quo[24:0], 1'b1};
        end else begin
          next_rem = remShift;
          next_quo = {quo[24:0], 1'b0};
        end
        next_cnt = cnt - 5'd1;
        if (cnt == 5'd1) begin
          next_state = AOS_DIV_DONE;
        end
      end
      AOS_DIV_DONE: begin
        // Ratio at one volt per unit, clamped.
        next_ratioMv = aos_sat(neg ? -32'(quo) : 32'(quo), `AOS_MV_MIN, `AOS_MV_MAX);
        // Negative or zero ratio forces floor.
        if (neg || quo == 26'h0) begin
          next_logMv = aos_sat(`AOS_LOG_MIN, `AOS_LOG_MIN, `AOS_LOG_MAX);
        end else begin
          // Log ratio one volt per unit.
          next_logMv = logMilli(quo);
        end
        next_state = AOS_DIV_IDLE;
      end
      default: begin
        next_state = AOS_DIV_IDLE;
      end
    endcase
  end

  // Registers the divider state and the results.
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state <= AOS_DIV_IDLE;
      quo <= 26'h0;
      rem <= 17'h0;
      dvs <= 16'h0;
      neg <= 1'b0;
      cnt <= 5'd0;
      ratioMv <= 16'sh0000;
      logMv <= 16'sh0000;
    end else begin
      state <= next_state;
      quo <= next_quo;
      rem <= next_rem;
      dvs <= next_dvs;
      neg <= next_neg;
      cnt <= next_cnt;
      ratioMv <= next_ratioMv;
      logMv <= next_logMv;
    end
  end

endmodule
`default_nettype wire

// File: hdl/aos_regs.svh
// Register offsets, field positions, reset values and counts of the output source selector.
`ifndef AOS_REGS_SVH
`define AOS_REGS_SVH

// Byte offsets on the register bus.
`define AOS_OFF_CTRL 8'h00
`define AOS_OFF_SEL 8'h04
`define AOS_OFF_LEVEL0 8'h08
`define AOS_OFF_LEVEL1 8'h0c
`define AOS_OFF_LEVEL2 8'h10
`define AOS_OFF_LEVEL3 8'h14
`define AOS_OFF_STATUS 8'h18
`define AOS_OFF_RATIO 8'h1c

// Field positions.
`define AOS_CTRL_NOISE_ON 0
`define AOS_STAT_WARN_LSB 0
`define AOS_STAT_REFUSED_LSB 4
`define AOS_STAT_FIX_ENABLE 8
`define AOS_STAT_FIX_DROP 9
`define AOS_SEL_W 4

// Reset values.
`define AOS_CTRL_RESET 1'b0
`define AOS_SEL_RESET 16'h9999
`define AOS_LEVEL_RESET 16'sh0000

// Sources that each output channel can be wired to, one bit per source code.
`define AOS_ALLOW_CH0 16'h3fff
`define AOS_ALLOW_CH1 16'h3fff
`define AOS_ALLOW_CH2 16'h13ff
`define AOS_ALLOW_CH3 16'h23ff

// Converter range and scaling limits in millivolts.
`define AOS_MV_MAX 32'sd10000
`define AOS_MV_MIN -32'sd10000
`define AOS_PCT_MAX 32'sd7500
`define AOS_LOG_MAX 32'sd2000
`define AOS_LOG_MIN -32'sd3000
`define AOS_MV_PER_RATIO 32'sd1000
`define AOS_MON_SCALE 32'sd10000
`define AOS_LOG10_2_MILLI 32'sd301
`define AOS_AUX_MIN_MV 16'd1

// Divider length in clock cycles.
`define AOS_DIV_STEPS 5'd26

`endif

// File: hdl/aos_scaler.sv
// Source multiplexer and scaling for one output channel.
`timescale 1ns/10ps
`default_nettype none
`include "aos_regs.svh"

module aos_scaler import aos_pkg::*; (
  input wire aos_src_e src,
  input wire logic signed [15:0] xPct,
  input wire logic signed [15:0] yPct,
  input wire logic signed [15:0] magPct,
  input wire logic signed [15:0] noisePct,
  input wire logic signed [15:0] phaseCdeg,
  input wire logic signed [15:0] eq1,
  input wire logic signed [15:0] eq2,
  input wire logic signed [15:0] level,
  input wire logic signed [15:0] adcMon,
  input wire logic signed [15:0] demod2Mon,
  input wire logic signed [15:0] aux1Mv,
  input wire logic signed [15:0] syncSine,
  input wire logic signed [15:0] ratioMv,
  input wire logic signed [15:0] logMv,
  output aos_mv_t mvOut
);

  // Raw full-scale sample to millivolts across the converter range.
  function automatic aos_mv_t monMv(input logic signed [15:0] s);
    return aos_sat((32'(s) * `AOS_MON_SCALE) >>> 15, `AOS_MV_MIN, `AOS_MV_MAX);
  endfunction

  // Hundredths of a percent to millivolts at 2.5 V per 100 percent.
  function automatic aos_mv_t pctMv(input logic signed [15:0] p, input logic signed [31:0] lo);
    return aos_sat(32'(p) >>> 2, lo, `AOS_PCT_MAX);
  endfunction

  // Picks and scales the selected quantity.
  always_comb begin
    case (src)
      AOS_SRC_X: mvOut = pctMv(xPct, -`AOS_PCT_MAX);
      AOS_SRC_Y: mvOut = pctMv(yPct, -`AOS_PCT_MAX);
      AOS_SRC_MAG: mvOut = pctMv(magPct, 32'sd0);
      AOS_SRC_PHASE: mvOut = aos_sat(32'(phaseCdeg) >>> 1, `AOS_MV_MIN, `AOS_MV_MAX);
      AOS_SRC_NOISE: mvOut = pctMv(noisePct, 32'sd0);
      AOS_SRC_RATIO: mvOut = ratioMv;
      AOS_SRC_LOGRATIO: mvOut = logMv;
      AOS_SRC_EQ1: mvOut = aos_sat(32'(eq1), `AOS_MV_MIN, `AOS_MV_MAX);
      AOS_SRC_EQ2: mvOut = aos_sat(32'(eq2), `AOS_MV_MIN, `AOS_MV_MAX);
      AOS_SRC_LEVEL: mvOut = level;
      AOS_SRC_ADCMON: mvOut = monMv(adcMon);
      AOS_SRC_DEMOD2MON: mvOut = monMv(demod2Mon);
      AOS_SRC_AUX1MON: mvOut = aos_sat(32'(aux1Mv), `AOS_MV_MIN, `AOS_MV_MAX);
      AOS_SRC_SYNC: mvOut = monMv(syncSine);
      default: mvOut = 16'sh0000;
    endcase
  end

endmodule
`default_nettype wire

// File: hdl/aos_top.sv
// Analog output source selector: register slave, selectors and four converter codes.
// Overview of operation
// - Y source: 2.5 V per 100 percent.
// - Magnitude: 2.5 V per 100 percent, unipolar.
// - Phase: 9 V at 180 degrees.
// - Noise: 2.5 V per 100 percent, unipolar.
// - Noise without noise mode warns, offers fixes.
// - Ratio is ten X fraction over aux volts.
// - Ratio output one volt per unit.
// - Log ratio one volt, -3 to +2.
// - Negative ratio forces log to -3.
// - Equation one: 10 V per 10000.
// - Equation two: 10 V per 10000.
// - User level outputs channel's own setting.
// - Main converter samples monitored.
// - Second demodulator input monitored.
// - Auxiliary input 1 voltage reproduced.
// - Reference sine from first demodulator.
// - X source: 2.5 V per 100 percent.
// - Levels within plus/minus 10 V, 1 mV.
// - Four selectors, each limited to wired sources.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "aos_regs.svh"

module aos_top import aos_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] xPct,
  input wire logic signed [15:0] yPct,
  input wire logic signed [15:0] magPct,
  input wire logic signed [15:0] noisePct,
  input wire logic signed [15:0] phaseCdeg,
  input wire logic signed [15:0] eq1,
  input wire logic signed [15:0] eq2,
  input wire logic signed [15:0] adcMon,
  input wire logic signed [15:0] demod2Mon,
  input wire logic signed [15:0] aux1Mv,
  input wire logic signed [15:0] syncSine,
  output logic signed [15:0] dacCode0,
  output logic signed [15:0] dacCode1,
  output logic signed [15:0] dacCode2,
  output logic signed [15:0] dacCode3,
  output logic noiseWarning
);

  // Tells whether a source may be routed to a given channel.
  function automatic logic srcAllowed(input int ch, input logic [3:0] s);
    logic [15:0] m;
    case (ch)
      0: m = `AOS_ALLOW_CH0;
      1: m = `AOS_ALLOW_CH1;
      2: m = `AOS_ALLOW_CH2;
      default: m = `AOS_ALLOW_CH3;
    endcase
    return m[s];
  endfunction

  // Clamps a written level into the settable window.
  function automatic aos_mv_t levelClamp(input logic [31:0] w);
    return aos_sat(32'(signed'(w[15:0])), `AOS_MV_MIN, `AOS_MV_MAX);
  endfunction

  logic rstMeta_n; // First reset synchroniser stage.
  logic rstSync_n; // Released reset used by the whole design.

  // Releases the reset through two flip-flops.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  logic noiseOn, next_noiseOn; // Noise measurement mode.
  logic [15:0] sel, next_sel; // Four 4-bit source codes.
  aos_mv_t level [4]; // User levels per channel.
  aos_mv_t next_level [4];
  logic [3:0] refused, next_refused; // Sticky refused-selection flags.
  logic [3:0] warn; // Channels selecting noise while noise mode is off.
  logic [31:0] next_prdata; // Read data for the coming access phase.
  logic setup; // Setup phase of a transfer.
  logic wrDone; // Write taking effect this edge.
  logic mapped; // Address hits a register.
  logic signed [15:0] ratioMv; // Ratio in millivolts.
  logic signed [15:0] logMv; // Log ratio in millivolts.
  aos_mv_t mv [4]; // Scaled code per channel before the output flops.

  // Decodes the bus phases and the address.
  always_comb begin
    setup = psel && !penable;
    wrDone = psel && penable && pwrite;
    case (paddr)
      `AOS_OFF_CTRL, `AOS_OFF_SEL, `AOS_OFF_LEVEL0, `AOS_OFF_LEVEL1,
      `AOS_OFF_LEVEL2, `AOS_OFF_LEVEL3, `AOS_OFF_STATUS, `AOS_OFF_RATIO: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    // Every access completes in its first access cycle.
    pready = psel && penable;
    pslverr = psel && penable && !mapped;
  end

  // Flags channels that carry noise while noise mode is off.
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      warn[c] = (sel[4 * c +: 4] == AOS_SRC_NOISE) && !noiseOn;
    end
    noiseWarning = |warn;
  end

  // Computes the register updates from a bus write.
  always_comb begin
    next_noiseOn = noiseOn;
    next_sel = sel;
    next_level = level;
    next_refused = refused;
    if (wrDone && mapped) begin
      case (paddr)
        `AOS_OFF_CTRL: begin
          next_noiseOn = pwdata[`AOS_CTRL_NOISE_ON];
        end
        `AOS_OFF_SEL: begin
          for (int c = 0; c < 4; c++) begin
            if (srcAllowed(c, pwdata[4 * c +: 4])) begin
              next_sel[4 * c +: 4] = pwdata[4 * c +: 4];
            end else begin
              next_refused[c] = 1'b1;
            end
          end
        end
        `AOS_OFF_LEVEL0: next_level[0] = levelClamp(pwdata);
        `AOS_OFF_LEVEL1: next_level[1] = levelClamp(pwdata);
        `AOS_OFF_LEVEL2: next_level[2] = levelClamp(pwdata);
        `AOS_OFF_LEVEL3: next_level[3] = levelClamp(pwdata);
        `AOS_OFF_STATUS: begin
          // Write-one clears refusals; only a selection write can set a refusal.
          next_refused = refused & ~pwdata[`AOS_STAT_REFUSED_LSB +: 4];
          if (pwdata[`AOS_STAT_FIX_ENABLE]) begin
            next_noiseOn = 1'b1;
          end
          if (pwdata[`AOS_STAT_FIX_DROP] && !noiseOn) begin
            for (int c = 0; c < 4; c++) begin
              if (sel[4 * c +: 4] == AOS_SRC_NOISE) begin
                next_sel[4 * c +: 4] = AOS_SRC_LEVEL;
              end
            end
          end
        end
        default: begin
          next_noiseOn = noiseOn;
        end
      endcase
    end
  end

  // Prepares read data during the setup phase.
  always_comb begin
    next_prdata = prdata;
    if (setup) begin
      case (paddr)
        `AOS_OFF_CTRL: next_prdata = {31'h0, noiseOn};
        `AOS_OFF_SEL: next_prdata = {16'h0, sel};
        `AOS_OFF_LEVEL0: next_prdata = {16'h0, level[0]};
        `AOS_OFF_LEVEL1: next_prdata = {16'h0, level[1]};
        `AOS_OFF_LEVEL2: next_prdata = {16'h0, level[2]};
        `AOS_OFF_LEVEL3: next_prdata = {16'h0, level[3]};
        `AOS_OFF_STATUS: next_prdata = {24'h0, refused, warn};
        `AOS_OFF_RATIO: next_prdata = {logMv, ratioMv};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  // Registers the control state and the read data.
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      noiseOn <= `AOS_CTRL_RESET;
      sel <= `AOS_SEL_RESET;
      level <= '{default: `AOS_LEVEL_RESET};
      refused <= 4'h0;
      prdata <= 32'h0;
    end else begin
      noiseOn <= next_noiseOn;
      sel <= next_sel;
      level <= next_level;
      refused <= next_refused;
      prdata <= next_prdata;
    end
  end

  // Shared ratio and log ratio engine.
  aos_ratio uRatio (
    .clk_sys(clk_sys),
    .rstSync_n(rstSync_n),
    .xPct(xPct),
    .aux1Mv(aux1Mv),
    .ratioMv(ratioMv),
    .logMv(logMv)
  );

  // One scaler per output channel.
  for (genvar c = 0; c < 4; c++) begin : gCh
    aos_scaler uScale (
      .src(aos_src_e'(sel[4 * c +: 4])),
      .xPct(xPct),
      .yPct(yPct),
      .magPct(magPct),
      .noisePct(noisePct),
      .phaseCdeg(phaseCdeg),
      .eq1(eq1),
      .eq2(eq2),
      .level(level[c]),
      .adcMon(adcMon),
      .demod2Mon(demod2Mon),
      .aux1Mv(aux1Mv),
      .syncSine(syncSine),
      .ratioMv(ratioMv),
      .logMv(logMv),
      .mvOut(mv[c])
    );
  end

  // Registers the converter codes; scalers, the ratio engine and level writes already clamp to full scale.
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      dacCode0 <= 16'sh0000;
      dacCode1 <= 16'sh0000;
      dacCode2 <= 16'sh0000;
      dacCode3 <= 16'sh0000;
    end else begin
      dacCode0 <= mv[0];
      dacCode1 <= mv[1];
      dacCode2 <= mv[2];
      dacCode3 <= mv[3];
    end
  end

endmodule
`default_nettype wire
